// ==== eabc_consts.vh ====
// Overview of operation
// - Eight external areas, size set by mode
// - Per-area eight or sixteen bit width
// - Per-area two or three state access
// - Per-area programmed wait states plus pin waits
// - Wait pin honoured only in three-state areas
// - DRAM only allowed in areas two to five
// - DRAM row/column multiplexing, 8/9/10 column bits
// - DRAM two column strobes, one per byte lane
// - Optional precharge cycle before row strobe
// - Refresh by CAS-before-RAS or self-refresh
// - Idle cycle between reads of different areas
// - Idle cycle between read and following write
// - Arbiter grants at most one master at once
// - Acknowledge asserted once bus is released
// - Active-low chip select per area 0-7
// - Address strobe while address valid, non-DRAM areas only
// - Read strobe during external reads of non-DRAM areas
// - Upper/lower write strobes by valid byte lane
// - Refresh flag bit 7 cleared only by zero
// - Mode-dependent width and release reset values
// - Width bit one means eight-bit area
// - State bit zero means no waits, two states in non-DRAM areas
// - Wait field gives zero to three waits
`ifndef EABC_CONSTS_VH
`define EABC_CONSTS_VH
`define EABC_A_BUS_RELEASE_CTRL 20'hee013
`define EABC_A_CHIP_SELECT_CTRL 20'hee01f
`define EABC_A_WIDTH 20'hee020
`define EABC_A_STATE 20'hee021
`define EABC_A_WAITU 20'hee022
`define EABC_A_WAITL 20'hee023
`define EABC_A_BUSCTL 20'hee024
`define EABC_A_DRAMA 20'hee026
`define EABC_A_DRAMB 20'hee027
`define EABC_A_RTCS 20'hee028
`define EABC_A_REFRESH_COUNTER 20'hee029
`define EABC_A_RTCMP 20'hee02a
`define EABC_R_BUS_RELEASE_CTRL 8'hfe
`define EABC_R_BUS_RELEASE_CTRL_M34 8'hee
`define EABC_R_CHIP_SELECT_CTRL 8'h0f
`define EABC_R_WIDTH 8'hff
`define EABC_R_WIDTH_M24 8'h00
`define EABC_R_STATE 8'hff
`define EABC_R_WAIT 8'hff
`define EABC_R_BUSCTL 8'hc6
`define EABC_R_DRAMA 8'h10
`define EABC_R_DRAMB 8'h08
`define EABC_R_RTCS 8'h07
`define EABC_R_REFRESH_COUNTER 8'h00
`define EABC_R_RTCMP 8'hff
`define EABC_B_BRLE 0
`define EABC_B_ICIS1 7
`define EABC_B_ICIS0 6
`define EABC_B_BROME 5
`define EABC_B_BRSTS1 4
`define EABC_B_CMF 7
`define EABC_B_CMIE 6
`define EABC_B_RFSH 3
`define EABC_B_SLFRF 4
`endif

// ==== eabc_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "eabc_consts.vh"
module eabc_top #(
	parameter ADDR_W = 24
) (
	// Clock and reset.
	input wire i_ref_clk,
	input wire i_rst_b,
	// Operating mode, sampled after reset release.
	input wire [2:0] i_mode,
	// Register port.
	input wire [19:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire i_reg_rd,
	output reg [7:0] o_reg_rdata,
	// Internal master requests.
	input wire i_cpu_req,
	input wire i_dma_req,
	input wire [ADDR_W-1:0] i_acc_addr,
	input wire i_acc_write,
	input wire [1:0] i_acc_bytes,
	output reg o_cpu_gnt,
	output reg o_dma_gnt,
	output reg o_acc_done,
	// External bus.
	output reg [ADDR_W-1:0] o_addr,
	output reg [7:0] o_chip_sel_n,
	output reg o_address_strobe_n,
	output reg o_read_strobe_n,
	output reg o_upper_write_strobe_n,
	output reg o_lower_write_strobe_n,
	output reg o_ras_n,
	output reg o_ucas_n,
	output reg o_lcas_n,
	output reg o_self_refresh,
	input wire i_wait_n,
	// External master arbitration and refresh flag.
	input wire i_bus_request_in_n,
	output reg o_bus_ack_n,
	output reg o_refresh_flag
);
	// ************************************************************
	// Registers.
	// ************************************************************
	reg [7:0] bus_release_ctrl, chip_select_ctrl, area_width_ctrl, area_state_ctrl;
	reg [7:0] wait_ctrl_upper, wait_ctrl_lower, bus_ctrl, dram_ctrl_a, dram_ctrl_b;
	reg [7:0] refresh_timer_ctrl_status, refresh_counter, refresh_compare;
	reg strap_done;
	reg [7:0] prescale;
	reg cmp_hit;
	wire wr = i_reg_wr;
	function [1:0] wait_of;
		input [2:0] a;
		input [15:0] w;
		begin
			wait_of = w[{a[2:0], 1'b0} +: 2];
		end
	endfunction
	function [7:0] tick_mask;
		input [2:0] s;
		begin
			tick_mask = (8'h01 << s) - 8'h01;
		end
	endfunction
	function is_dram;
		input [2:0] a;
		input [2:0] sel;
		begin
			// DRAM space is only ever areas 2 to 5; other codes select none.
			case (sel)
				3'h1: is_dram = (a == 3'h2);
				3'h2: is_dram = (a == 3'h2) || (a == 3'h3);
				3'h3, 3'h4: is_dram = (a >= 3'h2) && (a <= 3'h5);
				default: is_dram = 1'b0;
			endcase
		end
	endfunction
	// ************************************************************
	// Arbiter and access sequencer.
	// ************************************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_IDLECYC = 3'h1;
	localparam ST_T1 = 3'h2;
	localparam ST_T2 = 3'h3;
	localparam ST_T3 = 3'h4;
	localparam ST_PRE = 3'h5;
	localparam ST_REL = 3'h6;
	localparam ST_REF = 3'h7;
	localparam OWN_CPU = 2'h0;
	localparam OWN_DMA = 2'h1;
	localparam OWN_REF = 2'h2;
	localparam OWN_EXT = 2'h3;
	reg [2:0] state;
	reg [1:0] owner;
	reg [2:0] wcnt;
	reg [2:0] area;
	reg [2:0] last_area;
	reg last_read, last_valid;
	reg cur_write, cur_dram;
	reg [1:0] cur_bytes;
	reg [ADDR_W-1:0] cur_addr;
	reg ref_pend;
	wire [7:0] rt_mask = tick_mask(refresh_timer_ctrl_status[2:0]);
	wire mode_big = i_mode[2] | (i_mode == 3'h5);
	wire [2:0] next_area = mode_big ? i_acc_addr[23:21] : i_acc_addr[19:17];
	wire ext_req = ~i_bus_request_in_n & bus_release_ctrl[`EABC_B_BRLE];
	wire three = area_state_ctrl[area];
	wire [1:0] cfg_wait = three ? wait_of(area, {wait_ctrl_upper, wait_ctrl_lower}) : 2'h0;
	wire pin_wait = three & ~i_wait_n;
	wire idle_need = last_valid & last_read &
		((bus_ctrl[`EABC_B_ICIS1] & (last_area != next_area)) |
		(bus_ctrl[`EABC_B_ICIS0] & i_acc_write));
	wire [1:0] col_w = dram_ctrl_b[7:6];
	wire [ADDR_W-1:0] col_addr = (col_w == 2'h0) ? (cur_addr >> 8) :
		(col_w == 2'h1) ? (cur_addr >> 9) : (cur_addr >> 10);
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= ST_IDLE;
			owner <= OWN_CPU;
			wcnt <= 3'h0;
			area <= 3'h0;
			last_area <= 3'h0;
			last_read <= 1'b0;
			last_valid <= 1'b0;
			cur_write <= 1'b0;
			cur_dram <= 1'b0;
			cur_bytes <= 2'h0;
			cur_addr <= {ADDR_W{1'b0}};
			o_cpu_gnt <= 1'b0;
			o_dma_gnt <= 1'b0;
			o_acc_done <= 1'b0;
			o_addr <= {ADDR_W{1'b0}};
			o_chip_sel_n <= 8'hff;
			o_address_strobe_n <= 1'b1;
			o_read_strobe_n <= 1'b1;
			o_upper_write_strobe_n <= 1'b1;
			o_lower_write_strobe_n <= 1'b1;
			o_ras_n <= 1'b1;
			o_ucas_n <= 1'b1;
			o_lcas_n <= 1'b1;
			o_bus_ack_n <= 1'b1;
			o_self_refresh <= 1'b0;
		end else begin
			o_acc_done <= 1'b0;
			o_self_refresh <= dram_ctrl_b[`EABC_B_SLFRF] & (dram_ctrl_a[2:0] != 3'h0);
			case (state)
				ST_IDLE: begin
					o_cpu_gnt <= 1'b0;
					o_dma_gnt <= 1'b0;
					if (ext_req) begin
						owner <= OWN_EXT;
						state <= ST_REL;
						o_bus_ack_n <= 1'b0;
					end else if (ref_pend && !dram_ctrl_b[`EABC_B_SLFRF]) begin
						owner <= OWN_REF;
						state <= ST_REF;
						o_ucas_n <= 1'b0; // CAS before RAS.
						o_lcas_n <= 1'b0;
					end else if ((i_dma_req || i_cpu_req) && strap_done) begin
						owner <= i_dma_req ? OWN_DMA : OWN_CPU;
						o_dma_gnt <= i_dma_req;
						o_cpu_gnt <= ~i_dma_req;
						area <= next_area;
						cur_write <= i_acc_write;
						cur_bytes <= i_acc_bytes;
						cur_addr <= i_acc_addr;
						cur_dram <= is_dram(next_area, dram_ctrl_a[2:0]);
						if (idle_need)
							state <= ST_IDLECYC;
						else if (is_dram(next_area, dram_ctrl_a[2:0]) && dram_ctrl_b[5])
							state <= ST_PRE;
						else
							state <= ST_T1;
					end
				end
				ST_IDLECYC: begin
					last_valid <= 1'b0;
					state <= (cur_dram && dram_ctrl_b[5]) ? ST_PRE : ST_T1;
				end
				ST_PRE: state <= ST_T1;
				ST_T1: begin
					o_chip_sel_n <= ~(8'h01 << area);
					if (cur_dram) begin
						o_addr <= cur_addr; // Row first.
						o_ras_n <= 1'b0;
					end else begin
						o_addr <= cur_addr;
						o_address_strobe_n <= 1'b0;
						o_read_strobe_n <= cur_write;
					end
					// A three-state access spends one extra state in T3 before its waits.
					wcnt <= {1'b0, cfg_wait} + {2'h0, three | cur_dram};
					state <= ST_T2;
				end
				ST_T2: begin
					if (cur_dram) begin
						o_addr <= col_addr;
						o_ucas_n <= ~cur_bytes[1];
						o_lcas_n <= ~cur_bytes[0];
					end
					// An 8-bit area carries all data on the upper lane.
					o_upper_write_strobe_n <= ~(cur_write &
						(cur_bytes[1] | area_width_ctrl[area]));
					o_lower_write_strobe_n <= ~(cur_write & cur_bytes[0] & ~area_width_ctrl[area]);
					state <= ST_T3;
				end
				ST_T3: begin
					if (wcnt != 3'h0)
						wcnt <= wcnt - 3'h1;
					else if (!pin_wait) begin
						o_chip_sel_n <= 8'hff;
						o_address_strobe_n <= 1'b1;
						o_read_strobe_n <= 1'b1;
						o_upper_write_strobe_n <= 1'b1;
						o_lower_write_strobe_n <= 1'b1;
						o_ucas_n <= 1'b1;
						o_lcas_n <= 1'b1;
						o_ras_n <= 1'b1;
						o_acc_done <= 1'b1;
						last_area <= area;
						last_read <= ~cur_write;
						last_valid <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_REL: if (i_bus_request_in_n) begin
					o_bus_ack_n <= 1'b1;
					last_valid <= 1'b0;
					state <= ST_IDLE;
				end
				ST_REF: begin
					o_ras_n <= ~o_ras_n;
					if (!o_ras_n) begin
						o_ucas_n <= 1'b1;
						o_lcas_n <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// ************************************************************
	// Register port and refresh timer.
	// ************************************************************
	always @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			strap_done <= 1'b0;
			bus_release_ctrl <= `EABC_R_BUS_RELEASE_CTRL;
			chip_select_ctrl <= `EABC_R_CHIP_SELECT_CTRL;
			area_width_ctrl <= `EABC_R_WIDTH;
			area_state_ctrl <= `EABC_R_STATE;
			wait_ctrl_upper <= `EABC_R_WAIT;
			wait_ctrl_lower <= `EABC_R_WAIT;
			bus_ctrl <= `EABC_R_BUSCTL;
			dram_ctrl_a <= `EABC_R_DRAMA;
			dram_ctrl_b <= `EABC_R_DRAMB;
			refresh_timer_ctrl_status <= `EABC_R_RTCS;
			refresh_counter <= `EABC_R_REFRESH_COUNTER;
			refresh_compare <= `EABC_R_RTCMP;
			prescale <= 8'h00;
			ref_pend <= 1'b0;
			cmp_hit <= 1'b0;
			o_reg_rdata <= 8'h00;
			o_refresh_flag <= 1'b0;
		end else begin
			// Mode straps are caught once, after release, not under reset.
			if (!strap_done) begin
				strap_done <= 1'b1;
				if (i_mode == 3'h2 || i_mode == 3'h4)
					area_width_ctrl <= `EABC_R_WIDTH_M24;
				if (i_mode == 3'h3 || i_mode == 3'h4)
					bus_release_ctrl <= `EABC_R_BUS_RELEASE_CTRL_M34;
			end
			prescale <= prescale + 8'h01;
			cmp_hit <= 1'b0;
			if (refresh_timer_ctrl_status[2:0] != 3'h0 &&
				(prescale & rt_mask) == rt_mask) begin
				if (refresh_counter == refresh_compare) begin
					refresh_counter <= 8'h00;
					cmp_hit <= 1'b1;
				end else
					refresh_counter <= refresh_counter + 8'h01;
			end
			if (cmp_hit && dram_ctrl_b[`EABC_B_RFSH])
				ref_pend <= 1'b1;
			else if (state == ST_REF)
				ref_pend <= 1'b0;
			o_reg_rdata <= 8'h00;
			if (i_reg_rd) begin
				case (i_reg_addr)
					`EABC_A_BUS_RELEASE_CTRL: o_reg_rdata <= bus_release_ctrl;
					`EABC_A_CHIP_SELECT_CTRL: o_reg_rdata <= chip_select_ctrl;
					`EABC_A_WIDTH: o_reg_rdata <= area_width_ctrl;
					`EABC_A_STATE: o_reg_rdata <= area_state_ctrl;
					`EABC_A_WAITU: o_reg_rdata <= wait_ctrl_upper;
					`EABC_A_WAITL: o_reg_rdata <= wait_ctrl_lower;
					`EABC_A_BUSCTL: o_reg_rdata <= bus_ctrl;
					`EABC_A_DRAMA: o_reg_rdata <= dram_ctrl_a;
					`EABC_A_DRAMB: o_reg_rdata <= dram_ctrl_b;
					`EABC_A_RTCS: o_reg_rdata <= refresh_timer_ctrl_status;
					`EABC_A_REFRESH_COUNTER: o_reg_rdata <= refresh_counter;
					`EABC_A_RTCMP: o_reg_rdata <= refresh_compare;
					default: o_reg_rdata <= 8'h00;
				endcase
			end
			if (wr) begin
				case (i_reg_addr)
					`EABC_A_BUS_RELEASE_CTRL: bus_release_ctrl <= i_reg_wdata;
					`EABC_A_CHIP_SELECT_CTRL: chip_select_ctrl <= i_reg_wdata;
					`EABC_A_WIDTH: area_width_ctrl <= i_reg_wdata;
					`EABC_A_STATE: area_state_ctrl <= i_reg_wdata;
					`EABC_A_WAITU: wait_ctrl_upper <= i_reg_wdata;
					`EABC_A_WAITL: wait_ctrl_lower <= i_reg_wdata;
					`EABC_A_BUSCTL: bus_ctrl <= i_reg_wdata;
					`EABC_A_DRAMA: dram_ctrl_a <= i_reg_wdata;
					`EABC_A_DRAMB: dram_ctrl_b <= i_reg_wdata;
					`EABC_A_REFRESH_COUNTER: refresh_counter <= i_reg_wdata;
					`EABC_A_RTCMP: refresh_compare <= i_reg_wdata;
					default: ;
				endcase
			end
			// A compare hit in the clearing cycle wins, so no event is lost.
			if (cmp_hit)
				refresh_timer_ctrl_status[`EABC_B_CMF] <= 1'b1;
			else if (wr && i_reg_addr == `EABC_A_RTCS && !i_reg_wdata[7])
				refresh_timer_ctrl_status[`EABC_B_CMF] <= 1'b0;
			if (wr && i_reg_addr == `EABC_A_RTCS)
				refresh_timer_ctrl_status[6:0] <= i_reg_wdata[6:0];
			o_refresh_flag <= refresh_timer_ctrl_status[`EABC_B_CMF];
		end
	end
endmodule // eabc_top
`default_nettype wire

// ==== eabc_ext_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************
// Far-side memory and master.
// ****************
module eabc_ext_model (
	// Clock and bus.
	input wire logic i_ref_clk,
	input wire logic i_address_strobe_n,
	// Bench controls.
	input wire logic i_slow,
	input wire logic i_take_bus,
	// To the block.
	output logic o_wait_n,
	output logic o_bus_request_in_n
);
	logic [1:0] wcnt;
	initial begin
		o_wait_n = 1'b1;
		o_bus_request_in_n = 1'b1;
		wcnt = 2'd0;
	end
	// A slow device asks for three cycles once the strobe falls; the line idles high.
	always @(posedge i_ref_clk) begin
		if (i_address_strobe_n) wcnt <= 2'd0;
		else if (wcnt != 2'd3) wcnt <= wcnt + 2'd1;
		o_wait_n <= !(i_slow && !i_address_strobe_n && wcnt != 2'd3);
	end
	// The request is held for as long as the bench wants the bus.
	always @(posedge i_ref_clk) o_bus_request_in_n <= !i_take_bus;
endmodule // eabc_ext_model
`default_nettype wire

// ==== eabc_top_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "eabc_consts.vh"
// ****************
// Port checker.
// ****************
module eabc_top_asserts (
	// Clock, reset and registers.
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic [19:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	// Bus side.
	input wire logic [1:0] i_acc_bytes,
	input wire logic o_cpu_gnt,
	input wire logic o_dma_gnt,
	input wire logic [7:0] o_chip_sel_n,
	input wire logic o_read_strobe_n,
	input wire logic o_upper_write_strobe_n,
	input wire logic o_lower_write_strobe_n,
	input wire logic i_bus_request_in_n,
	input wire logic o_bus_ack_n,
	input wire logic o_refresh_flag
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	wire flag_clr = i_reg_wr && i_reg_addr == `EABC_A_RTCS && !i_reg_wdata[`EABC_B_CMF];
	property p_one_grant; !(o_cpu_gnt && o_dma_gnt); endproperty
	a_one_grant: assert property (p_one_grant) else $error("two grants");
	property p_ack_alone; !o_bus_ack_n |-> !o_cpu_gnt && !o_dma_gnt; endproperty
	a_ack_alone: assert property (p_ack_alone) else $error("grant while released");
	property p_ack_cause; $fell(o_bus_ack_n) |-> $past(i_bus_request_in_n) == 1'b0; endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_ack_drop; $rose(i_bus_request_in_n) |-> ##[0:3] o_bus_ack_n; endproperty
	a_ack_drop: assert property (p_ack_drop) else $error("ack held");
	property p_cs_one; $onehot0(~o_chip_sel_n); endproperty
	a_cs_one: assert property (p_cs_one) else $error("several selects");
	property p_rd_only; !o_read_strobe_n |-> o_upper_write_strobe_n && o_lower_write_strobe_n;
	endproperty
	a_rd_only: assert property (p_rd_only) else $error("read with write");
	property p_low_lane; !o_lower_write_strobe_n |-> i_acc_bytes[0]; endproperty
	a_low_lane: assert property (p_low_lane) else $error("lower lane unused");
	property p_flag_clr; $fell(o_refresh_flag) |-> $past(flag_clr) || $past(flag_clr, 2);
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag cleared alone");
	property p_rdata_idle; !$past(i_reg_rd) |-> o_reg_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
endmodule // eabc_top_asserts
`default_nettype wire

// ==== external_area_bus_controller_test.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "eabc_consts.vh"
// ****************
// Self-checking bench.
// ****************
module external_area_bus_controller_test;
	logic i_ref_clk, i_rst_b, i_reg_wr, i_reg_rd, i_cpu_req, i_dma_req, i_acc_write;
	logic [2:0] i_mode;
	logic [19:0] i_reg_addr;
	logic [7:0] i_reg_wdata;
	logic [23:0] i_acc_addr;
	logic [1:0] i_acc_bytes;
	wire [7:0] o_reg_rdata, o_chip_sel_n;
	wire [23:0] o_addr;
	wire o_cpu_gnt, o_dma_gnt, o_acc_done, o_address_strobe_n, o_read_strobe_n;
	wire o_upper_write_strobe_n, o_lower_write_strobe_n, o_ras_n, o_ucas_n, o_lcas_n;
	wire o_self_refresh, o_bus_ack_n, o_refresh_flag, i_wait_n, i_bus_request_in_n;
	logic slow, take_bus, rd_d, narrow;
	logic [31:0] seed;
	logic [7:0] exp_q[$];
	int num_errors, samples_checked, lat, base;
	logic [19:0] ra[12] = '{`EABC_A_BUS_RELEASE_CTRL, `EABC_A_CHIP_SELECT_CTRL, `EABC_A_WIDTH, `EABC_A_STATE,
		`EABC_A_WAITU, `EABC_A_WAITL, `EABC_A_BUSCTL, `EABC_A_DRAMA, `EABC_A_DRAMB,
		`EABC_A_RTCS, `EABC_A_REFRESH_COUNTER, `EABC_A_RTCMP};
	logic [7:0] rv[12] = '{`EABC_R_BUS_RELEASE_CTRL, `EABC_R_CHIP_SELECT_CTRL, `EABC_R_WIDTH, `EABC_R_STATE,
		`EABC_R_WAIT, `EABC_R_WAIT, `EABC_R_BUSCTL, `EABC_R_DRAMA, `EABC_R_DRAMB,
		`EABC_R_RTCS, `EABC_R_REFRESH_COUNTER, `EABC_R_RTCMP};
	eabc_top i_eabc_top (.*);
	eabc_ext_model i_eabc_ext_model (.i_ref_clk(i_ref_clk), .i_address_strobe_n(o_address_strobe_n),
		.i_slow(slow), .i_take_bus(take_bus), .o_wait_n(i_wait_n),
		.o_bus_request_in_n(i_bus_request_in_n));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic ok);
		samples_checked++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("unexpected at %0t: value differs", $time);
		end
	endtask
	task automatic give_up(input logic ok);
		chk(ok);
		if (ok !== 1'b1) test_done();
	endtask
	// Strobes are left up between back-to-back operations and dropped by reg_end.
	task automatic reg_op(input logic w, input logic [19:0] a, input logic [7:0] d);
		{i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {w, !w, a, d};
		if (!w) exp_q.push_back(d);
		@(posedge i_ref_clk);
	endtask
	task automatic reg_end;
		{i_reg_wr, i_reg_rd} <= 2'b00;
		@(posedge i_ref_clk);
	endtask
	task automatic reset_to(input logic [2:0] m);
		{i_rst_b, i_mode} <= {1'b0, m};
		repeat (3) @(posedge i_ref_clk);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
	endtask
	task automatic acc(input logic [1:0] who, input logic [2:0] ar, input logic w,
		input logic [1:0] b);
		int n;
		logic su, sl;
		{n, su, sl} = '0;
		seed = xs(seed);
		i_acc_addr <= {4'h0, ar, seed[16:1], 1'b0};
		{i_acc_write, i_acc_bytes, i_dma_req, i_cpu_req} <= {w, b, who};
		do begin
			@(posedge i_ref_clk);
			n++;
			if (o_dma_gnt === 1'b1) i_dma_req <= 1'b0;
			if (o_cpu_gnt === 1'b1) i_cpu_req <= 1'b0;
			su |= !o_upper_write_strobe_n;
			sl |= !o_lower_write_strobe_n;
			if (!o_address_strobe_n && ar < 4) chk(o_chip_sel_n === ~(8'h01 << ar));
		end while (o_acc_done !== 1'b1 && n < 60);
		give_up(o_acc_done === 1'b1);
		lat = n;
		chk(su === (w && (b[1] || narrow)) && sl === (w && b[0] && !narrow));
	endtask
	task automatic wait_ack(input logic v);
		int n;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_bus_ack_n !== v && n < 10);
		give_up(o_bus_ack_n === v);
	endtask
	always @(posedge i_ref_clk) begin
		rd_d <= i_reg_rd;
		if (rd_d && exp_q.size() > 0) chk(o_reg_rdata === exp_q.pop_front());
	end
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	initial begin
		int i, m;
		logic [7:0] e;
		{i_rst_b, i_reg_wr, i_reg_rd, i_cpu_req, i_dma_req, i_acc_write, slow, take_bus,
			narrow} = '0;
		{i_reg_addr, i_reg_wdata, i_acc_addr, i_acc_bytes, rd_d} = '0;
		{i_mode, num_errors, samples_checked, seed} = {3'd1, 64'd0, 32'h08157b9a};
		for (m = 1; m < 5; m++) begin
			reset_to(m[2:0]);
			for (i = 0; i < 12; i++) begin
				e = rv[i];
				if (i == 0 && m > 2) e = `EABC_R_BUS_RELEASE_CTRL_M34;
				if (i == 2 && m % 2 == 0) e = `EABC_R_WIDTH_M24;
				reg_op(1'b0, ra[i], e);
			end
			reg_end();
		end
		for (i = 2; i < 6; i++) begin
			seed = xs(seed);
			reg_op(1'b1, ra[i], seed[7:0]);
			reg_op(1'b0, ra[i], seed[7:0]);
		end
		reg_op(1'b1, 20'hee025, 8'hff);
		reg_op(1'b0, 20'hee025, 8'h00);
		reg_end();
		$display("done: registers");
		reset_to(3'd1);
		reg_op(1'b1, `EABC_A_STATE, 8'h00);
		reg_op(1'b1, `EABC_A_WIDTH, 8'h00);
		reg_end();
		acc(2'b01, 3'd0, 1'b0, 2'b11);
		acc(2'b10, 3'd0, 1'b0, 2'b11);
		base = lat;
		acc(2'b01, 3'd1, 1'b0, 2'b11);
		chk(lat == base + 1);
		acc(2'b01, 3'd1, 1'b1, 2'b10);
		chk(lat == base + 1);
		reg_op(1'b1, `EABC_A_BUSCTL, `EABC_R_BUSCTL & 8'h3f);
		reg_end();
		acc(2'b01, 3'd1, 1'b0, 2'b11);
		acc(2'b01, 3'd2, 1'b0, 2'b11);
		chk(lat == base);
		acc(2'b10, 3'd2, 1'b1, 2'b01);
		chk(lat == base);
		$display("done: idle cycles");
		for (m = 0; m < 5; m++) begin
			reg_op(1'b1, `EABC_A_STATE, m < 4 ? 8'hff : 8'h00);
			reg_op(1'b1, `EABC_A_WAITL, {4{m[1:0]}});
			reg_end();
			slow <= (m == 0 || m == 4);
			acc(2'b01, 3'd3, 1'b0, 2'b11);
			acc(2'b10, 3'd3, 1'b0, 2'b11);
			if (m == 0) chk(lat > base);
			else chk(lat == base + (m == 4 ? 0 : m + 1));
		end
		$display("done: wait states");
		slow <= 1'b0;
		reg_op(1'b1, `EABC_A_WIDTH, 8'hff);
		reg_end();
		narrow <= 1'b1;
		acc(2'b01, 3'd0, 1'b0, 2'b11);
		acc(2'b01, 3'd0, 1'b1, 2'b01);
		chk(lat == base);
		acc(2'b11, 3'd0, 1'b0, 2'b11);
		chk(i_cpu_req === 1'b1);
		acc(2'b01, 3'd0, 1'b0, 2'b11);
		$display("done: width and priority");
		reg_op(1'b1, `EABC_A_BUS_RELEASE_CTRL, 8'hff);
		reg_end();
		take_bus <= 1'b1;
		wait_ack(1'b0);
		i_cpu_req <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		chk(o_cpu_gnt === 1'b0);
		{take_bus, i_cpu_req} <= 2'b00;
		wait_ack(1'b1);
		$display("done: bus release");
		reg_op(1'b1, `EABC_A_RTCMP, 8'h01);
		reg_op(1'b1, `EABC_A_RTCS, 8'h01);
		reg_end();
		i = 0;
		do begin
			@(posedge i_ref_clk);
			i++;
		end while (o_refresh_flag !== 1'b1 && i < 300);
		give_up(o_refresh_flag === 1'b1);
		reg_op(1'b1, `EABC_A_RTCMP, 8'hff);
		reg_op(1'b1, `EABC_A_RTCS, 8'h81);
		reg_op(1'b0, `EABC_A_RTCS, 8'h81);
		reg_op(1'b1, `EABC_A_RTCS, 8'h01);
		reg_op(1'b0, `EABC_A_RTCS, 8'h01);
		reg_end();
		$display("done: refresh flag");
		test_done();
	end
endmodule // external_area_bus_controller_test
bind eabc_top eabc_top_asserts i_eabc_top_asserts (.*);
`default_nettype wire
